// >>> logic/psce_params.svh
// register select codes, field positions, condition codes and reset values
// assumes inclusion by the sequencer package and the sequencer module
`ifndef PSCE_PARAMS_SVH
`define PSCE_PARAMS_SVH
// ****************************************
// universal register select codes
// ****************************************
`define PSCE_R_FETCH      5'h00
`define PSCE_R_DECODE     5'h01
`define PSCE_R_EXEC       5'h02
`define PSCE_R_RSTK_TOP   5'h03
`define PSCE_R_RSTK_PTR   5'h04
`define PSCE_R_LSTK_TOP   5'h05
`define PSCE_R_CUR_CNT    5'h06
`define PSCE_R_NXT_CNT    5'h07
`define PSCE_R_SYS_BASE   5'h08
`define PSCE_R_SYS_LAST   5'h10
// ****************************************
// system register slots (select minus base)
// ****************************************
`define PSCE_S_MODE_CONTROL_FIRST      4'h0
`define PSCE_S_MODE_CONTROL_SECOND      4'h1
`define PSCE_S_IRPT       4'h2
`define PSCE_S_IRQ_ENABLE_MASK      4'h3
`define PSCE_S_IRQ_NESTING_POINTER     4'h4
`define PSCE_S_ARITH      4'h5
`define PSCE_S_STICKY     4'h6
`define PSCE_S_USER1      4'h7
`define PSCE_S_USER2      4'h8
// ****************************************
// fields, codes, constants
// ****************************************
`define PSCE_BTF_BIT      18
`define PSCE_BM_EN0_BIT   17
`define PSCE_BM_EN1_BIT   18
`define PSCE_CC_EXPIRED   5'h0F
`define PSCE_CC_CPL_BASE  5'h10
`define PSCE_CC_ALWAYS    5'h1F
`define PSCE_CNT_ONE      32'h0000_0001
`define PSCE_ADDR_ONE     24'h00_0001
`define PSCE_PTR_EMPTY    5'h00
`define PSCE_PTR_OVF      5'h1F
`define PSCE_RST_ZERO     32'h0000_0000
`define PSCE_VEC_BASE     24'h00_0000
`define PSCE_VEC_SHIFT    2
`endif

// >>> logic/psce_pkg.sv
// shared types of the program sequencer
// assumes psce_params.svh on the include path
`include "psce_params.svh"
package psce_pkg;
  typedef enum logic [2:0] {
    PSCE_BIT_SET,
    PSCE_BIT_CLR,
    PSCE_BIT_TGL,
    PSCE_BIT_TST,
    PSCE_BIT_XOR
  } psce_bitop_t;
endpackage : psce_pkg

// >>> logic/psce_sequencer.sv
// program sequencer: fetch address, cache, stacks, system registers, conditions
// assumes single core clock; program memory answers in the same cycle
// Functional notes
// - fetch address increments when flow is linear
// - conflict miss defers fetch, fills cache
// - cache checked each data access, hit no stall
// - call pushes return address, jump does not
// - all registers readable; three addresses read-only
// - stack pointer write moves return stack
// - stack pointer one extra read/effect cycle
// - loop and status stacks need dedicated instructions
// - latency zero visible next cycle
// - mode/irq-mask/status registers effect one cycle later; irq latch immediate
// - nesting pointer one extra read/effect cycle
// - stack tops, counts, user flags immediate
// - bit instruction sets clears toggles tests bits
// - arith bit 18 is test flag, code 13
// - codes 16-30 complement codes 0-14
// - codes 0-8 test compute unit flags
// - codes 9-12 test general flag inputs
// - code 15 expired in loop, else not
// - always-true runs, never-true loops forever
// - code 31 true in conditions, false terminating
// - bus owner code needs mode bits clear
// - count test uses count before write lands
// - loop repeats until termination condition true
// - interrupt masking and vector generation
`timescale 1ns/10ps
`include "psce_params.svh"
module psce_sequencer #(
  parameter int CACHE_DEPTH = 32,
  parameter int RSTK_DEPTH  = 30,
  parameter int LSTK_DEPTH  = 6,
  parameter int SSTK_DEPTH  = 5
) (
  input  wire logic               i_clk,
  input  wire logic               i_resetn,
  input  wire logic [47:0]        i_pm_instr,
  input  wire logic               i_pm_data_access,
  input  wire logic               i_branch,
  input  wire logic               i_is_call,
  input  wire logic [23:0]        i_branch_target,
  input  wire logic               i_return,
  input  wire logic               i_loop_start,
  input  wire logic [31:0]        i_loop_end_word,
  input  wire logic               i_loop_end,
  input  wire logic               i_loop_pop,
  input  wire logic               i_sstk_push,
  input  wire logic               i_sstk_pop,
  input  wire logic               i_ureg_wr,
  input  wire logic [4:0]         i_ureg_sel,
  input  wire logic [31:0]        i_ureg_wdata,
  input  wire logic               i_bitop_en,
  input  wire psce_pkg::psce_bitop_t i_bitop,
  input  wire logic [31:0]        i_bit_mask,
  input  wire logic [4:0]         i_cond_code,
  input  wire logic               i_cond_is_loop,
  input  wire logic [31:0]        i_irq_req,
  input  wire logic               i_alu_zero_flag,
  input  wire logic               i_alu_lt,
  input  wire logic               i_alu_le,
  input  wire logic               i_alu_carry_flag,
  input  wire logic               i_alu_overflow_flag,
  input  wire logic               i_mult_overflow_flag,
  input  wire logic               i_mult_negative_flag,
  input  wire logic               i_shift_overflow_flag,
  input  wire logic               i_shift_zero_flag,
  input  wire logic               i_gp_input_zero,
  input  wire logic               i_gp_input_one,
  input  wire logic               i_gp_input_two,
  input  wire logic               i_gp_input_three,
  input  wire logic               i_bus_owner,
  output logic [23:0]             o_fetch_address,
  output logic [47:0]             o_instr,
  output logic                    o_instr_valid,
  output logic                    o_fetch_stall,
  output logic [31:0]             o_ureg_rdata,
  output logic                    o_cond_true,
  output logic                    o_irq_take,
  output logic [23:0]             o_irq_vector
);
  import psce_pkg::*;

  localparam int IW = $clog2(CACHE_DEPTH);
  localparam int TW = 24 - IW;

  if (CACHE_DEPTH < 2 || (1 << IW) != CACHE_DEPTH || RSTK_DEPTH > 30 || RSTK_DEPTH < 1
      || LSTK_DEPTH < 1 || LSTK_DEPTH > 15 || SSTK_DEPTH < 1 || SSTK_DEPTH > 15) begin : g_bad_param
    $error("psce_sequencer: unsupported depth parameter");
  end

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [23:0]                  fa;
    logic [23:0]                  da;
    logic [23:0]                  pc;
    logic [47:0]                  instr;
    logic                         ivld;
    logic                         stall;
    logic [CACHE_DEPTH-1:0]       cv;
    logic [CACHE_DEPTH-1:0][TW-1:0] ctag;
    logic [CACHE_DEPTH-1:0][47:0] cdat;
    logic [RSTK_DEPTH-1:0][23:0]  rstk;
    logic [4:0]                   rsp;
    logic                         rsp_pv;
    logic [4:0]                   rsp_pd;
    logic [LSTK_DEPTH-1:0][31:0]  lstk;
    logic [3:0]                   lsp;
    logic [SSTK_DEPTH-1:0][63:0]  sstk;
    logic [3:0]                   ssp;
    logic [31:0]                  cur;
    logic [31:0]                  nxt;
    logic [8:0][31:0]             sys;
    logic [8:0][31:0]             eff;
    logic                         imp_pv;
    logic [31:0]                  imp_pd;
    logic [31:0]                  rdata;
    logic                         cond;
    logic                         irq_take;
    logic [23:0]                  irq_vec;
    logic [3:0]                   fs1;
    logic [3:0]                   fs2;
  } psce_state_t;

  psce_state_t s_ff;
  psce_state_t nxt_s;

  // ****************************************
  // condition evaluation
  // ****************************************
  function automatic logic eval_cond(input logic [4:0] code, input logic in_loop,
                                     input logic [14:0] base, input logic [31:0] cnt);
    logic r;
    r = 1'b0;
    if (code < `PSCE_CC_EXPIRED) begin
      r = base[code[3:0]];
    end else if (code == `PSCE_CC_EXPIRED) begin
      r = in_loop ? (cnt == `PSCE_CNT_ONE) : (cnt != `PSCE_CNT_ONE);
    end else if (code == `PSCE_CC_ALWAYS) begin
      r = !in_loop;
    end else begin
      r = !base[4'(code - `PSCE_CC_CPL_BASE)];
    end
    return r;
  endfunction : eval_cond

  logic [14:0]    cbase;
  logic [IW-1:0]  cidx;
  logic           chit;
  logic           miss_stall;
  logic           loop_done;
  logic           redirect;
  logic           irq_any;
  logic [4:0]     irq_idx;

  always_comb begin
    cbase = {i_bus_owner & ~s_ff.eff[`PSCE_S_MODE_CONTROL_FIRST][`PSCE_BM_EN0_BIT]
                         & ~s_ff.eff[`PSCE_S_MODE_CONTROL_FIRST][`PSCE_BM_EN1_BIT],
             s_ff.eff[`PSCE_S_ARITH][`PSCE_BTF_BIT],
             s_ff.fs2,
             i_shift_zero_flag, i_shift_overflow_flag, i_mult_negative_flag, i_mult_overflow_flag,
             i_alu_overflow_flag, i_alu_carry_flag, i_alu_le, i_alu_lt, i_alu_zero_flag};
    cidx       = s_ff.fa[IW-1:0];
    chit       = s_ff.cv[cidx] && (s_ff.ctag[cidx] == s_ff.fa[23:IW]);
    miss_stall = i_pm_data_access && !chit && !s_ff.stall;
    loop_done  = eval_cond(s_ff.lstk[4'(s_ff.lsp - 4'h1)][28:24], 1'b1, cbase, s_ff.cur);
    irq_any    = 1'b0;
    irq_idx    = 5'h00;
    for (int k = 31; k >= 0; k--) begin
      if (s_ff.sys[`PSCE_S_IRPT][k] && s_ff.eff[`PSCE_S_IRQ_ENABLE_MASK][k]) begin
        irq_any = 1'b1;
        irq_idx = 5'(k);
      end
    end
    redirect = irq_any || i_branch || i_return || (i_loop_end && s_ff.lsp != 4'h0);
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic [3:0]  si;
    logic [31:0] bv;
    logic [23:0] rtop;
    logic [4:0]  rsp_w;
    nxt_s      = s_ff;
    si         = 4'(i_ureg_sel - `PSCE_R_SYS_BASE);
    bv         = s_ff.sys[si];
    rtop       = (s_ff.rsp == `PSCE_PTR_EMPTY) ? 24'h00_0000 : s_ff.rstk[5'(s_ff.rsp - 5'h01)];
    rsp_w      = s_ff.rsp;
    nxt_s.fs1  = {i_gp_input_three, i_gp_input_two, i_gp_input_one, i_gp_input_zero};
    nxt_s.fs2  = s_ff.fs1;
    nxt_s.irq_take = 1'b0;
    // effect view trails the read view by one cycle
    nxt_s.eff  = s_ff.sys;
    nxt_s.rsp_pv = 1'b0;
    nxt_s.imp_pv = 1'b0;

    // fetch path
    nxt_s.stall = miss_stall;
    nxt_s.ivld  = !miss_stall;
    if (s_ff.stall) begin
      nxt_s.instr      = i_pm_instr;
      nxt_s.cv[cidx]   = 1'b1;
      nxt_s.ctag[cidx] = s_ff.fa[23:IW];
      nxt_s.cdat[cidx] = i_pm_instr;
    end else if (i_pm_data_access && chit) begin
      nxt_s.instr = s_ff.cdat[cidx];
    end else if (!miss_stall) begin
      nxt_s.instr = i_pm_instr;
    end
    if (!miss_stall || redirect) begin
      nxt_s.pc = s_ff.da;
      nxt_s.da = s_ff.fa;
      nxt_s.fa = s_ff.fa + `PSCE_ADDR_ONE;
    end

    // register reads
    unique case (i_ureg_sel)
      `PSCE_R_FETCH:    nxt_s.rdata = {8'h00, s_ff.fa};
      `PSCE_R_DECODE:   nxt_s.rdata = {8'h00, s_ff.da};
      `PSCE_R_EXEC:     nxt_s.rdata = {8'h00, s_ff.pc};
      `PSCE_R_RSTK_TOP: nxt_s.rdata = {8'h00, rtop};
      `PSCE_R_RSTK_PTR: nxt_s.rdata = {27'h000_0000, s_ff.rsp};
      `PSCE_R_LSTK_TOP: nxt_s.rdata = (s_ff.lsp == 4'h0) ? `PSCE_RST_ZERO : s_ff.lstk[4'(s_ff.lsp - 4'h1)];
      `PSCE_R_CUR_CNT:  nxt_s.rdata = s_ff.cur;
      `PSCE_R_NXT_CNT:  nxt_s.rdata = s_ff.nxt;
      default:          nxt_s.rdata = (i_ureg_sel > `PSCE_R_SYS_LAST) ? `PSCE_RST_ZERO : bv;
    endcase

    // register writes; address registers have no write path
    if (i_ureg_wr) begin
      unique case (i_ureg_sel)
        `PSCE_R_RSTK_TOP: if (s_ff.rsp != `PSCE_PTR_EMPTY && s_ff.rsp <= 5'(RSTK_DEPTH))
                            nxt_s.rstk[5'(s_ff.rsp - 5'h01)] = i_ureg_wdata[23:0];
        `PSCE_R_RSTK_PTR: begin
          nxt_s.rsp_pv = 1'b1;
          nxt_s.rsp_pd = i_ureg_wdata[4:0];
        end
        `PSCE_R_LSTK_TOP: if (s_ff.lsp != 4'h0) nxt_s.lstk[4'(s_ff.lsp - 4'h1)] = i_ureg_wdata;
        `PSCE_R_CUR_CNT:  nxt_s.cur = i_ureg_wdata;
        `PSCE_R_NXT_CNT:  nxt_s.nxt = i_ureg_wdata;
        default: begin
          if (i_ureg_sel >= `PSCE_R_SYS_BASE && i_ureg_sel <= `PSCE_R_SYS_LAST) begin
            if (si == `PSCE_S_IRQ_NESTING_POINTER) begin
              nxt_s.imp_pv = 1'b1;
              nxt_s.imp_pd = i_ureg_wdata;
            end else begin
              nxt_s.sys[si] = i_ureg_wdata;
            end
          end
        end
      endcase
    end

    // bit manipulation on a system register
    if (i_bitop_en && i_ureg_sel >= `PSCE_R_SYS_BASE && i_ureg_sel <= `PSCE_R_SYS_LAST) begin
      unique case (i_bitop)
        PSCE_BIT_SET: nxt_s.sys[si] = bv | i_bit_mask;
        PSCE_BIT_CLR: nxt_s.sys[si] = bv & ~i_bit_mask;
        PSCE_BIT_TGL: nxt_s.sys[si] = bv ^ i_bit_mask;
        PSCE_BIT_TST: nxt_s.sys[`PSCE_S_ARITH][`PSCE_BTF_BIT] = ((bv & i_bit_mask) == i_bit_mask);
        PSCE_BIT_XOR: nxt_s.sys[`PSCE_S_ARITH][`PSCE_BTF_BIT] = (bv == i_bit_mask);
        default:      nxt_s.sys[si] = bv;
      endcase
    end

    // delayed landing of the pointer registers
    if (s_ff.imp_pv) nxt_s.sys[`PSCE_S_IRQ_NESTING_POINTER] = s_ff.imp_pd;
    if (s_ff.rsp_pv && s_ff.rsp != `PSCE_PTR_OVF) begin
      rsp_w = (s_ff.rsp_pd > 5'(RSTK_DEPTH) && s_ff.rsp_pd != `PSCE_PTR_OVF) ? 5'(RSTK_DEPTH) : s_ff.rsp_pd;
    end

    // loop and status stacks move only on dedicated instructions
    if (i_loop_start) begin
      if (s_ff.lsp != 4'(LSTK_DEPTH)) begin
        nxt_s.lstk[s_ff.lsp] = i_loop_end_word;
        nxt_s.lsp = s_ff.lsp + 4'h1;
      end
      nxt_s.cur = s_ff.nxt;
      if (rsp_w < 5'(RSTK_DEPTH)) nxt_s.rstk[rsp_w] = s_ff.da;
      rsp_w = (rsp_w < 5'(RSTK_DEPTH)) ? rsp_w + 5'h01 : `PSCE_PTR_OVF;
    end else if ((i_loop_end && s_ff.lsp != 4'h0 && loop_done) || i_loop_pop) begin
      if (s_ff.lsp != 4'h0) nxt_s.lsp = s_ff.lsp - 4'h1;
      if (rsp_w != `PSCE_PTR_EMPTY && rsp_w != `PSCE_PTR_OVF) rsp_w = rsp_w - 5'h01;
    end else if (i_loop_end && s_ff.lsp != 4'h0) begin
      nxt_s.cur = s_ff.cur - `PSCE_CNT_ONE;
    end
    if (i_sstk_push && s_ff.ssp != 4'(SSTK_DEPTH)) begin
      nxt_s.sstk[s_ff.ssp] = {s_ff.sys[`PSCE_S_MODE_CONTROL_FIRST], s_ff.sys[`PSCE_S_ARITH]};
      nxt_s.ssp = s_ff.ssp + 4'h1;
    end else if (i_sstk_pop && s_ff.ssp != 4'h0) begin
      {nxt_s.sys[`PSCE_S_MODE_CONTROL_FIRST], nxt_s.sys[`PSCE_S_ARITH]} = s_ff.sstk[4'(s_ff.ssp - 4'h1)];
      nxt_s.ssp = s_ff.ssp - 4'h1;
    end

    // irq latch: requests win over a clearing write
    nxt_s.sys[`PSCE_S_IRPT] = nxt_s.sys[`PSCE_S_IRPT] | i_irq_req;

    // change of flow, highest first
    if (irq_any) begin
      nxt_s.irq_take = 1'b1;
      nxt_s.irq_vec  = `PSCE_VEC_BASE + ({19'h0_0000, irq_idx} << `PSCE_VEC_SHIFT);
      nxt_s.sys[`PSCE_S_IRPT][irq_idx] = i_irq_req[irq_idx];
      nxt_s.fa = `PSCE_VEC_BASE + ({19'h0_0000, irq_idx} << `PSCE_VEC_SHIFT);
      if (rsp_w < 5'(RSTK_DEPTH)) nxt_s.rstk[rsp_w] = s_ff.da;
      rsp_w = (rsp_w < 5'(RSTK_DEPTH)) ? rsp_w + 5'h01 : `PSCE_PTR_OVF;
    end else if (i_branch) begin
      nxt_s.fa = i_branch_target;
      if (i_is_call && !i_loop_start) begin
        if (rsp_w < 5'(RSTK_DEPTH)) nxt_s.rstk[rsp_w] = s_ff.da;
        rsp_w = (rsp_w < 5'(RSTK_DEPTH)) ? rsp_w + 5'h01 : `PSCE_PTR_OVF;
      end
    end else if (i_return) begin
      nxt_s.fa = rtop;
      if (rsp_w != `PSCE_PTR_EMPTY && rsp_w != `PSCE_PTR_OVF) rsp_w = rsp_w - 5'h01;
    end else if (i_loop_end && s_ff.lsp != 4'h0 && !loop_done) begin
      nxt_s.fa = rtop;
    end
    nxt_s.rsp = rsp_w;

    // condition result, against the count before any write lands
    nxt_s.cond = eval_cond(i_cond_code, i_cond_is_loop, cbase, s_ff.cur);
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign o_fetch_address = s_ff.fa;
  assign o_instr         = s_ff.instr;
  assign o_instr_valid   = s_ff.ivld;
  assign o_fetch_stall   = s_ff.stall;
  assign o_ureg_rdata    = s_ff.rdata;
  assign o_cond_true     = s_ff.cond;
  assign o_irq_take      = s_ff.irq_take;
  assign o_irq_vector    = s_ff.irq_vec;

  // ****************************************
  // checks
  // ****************************************
  logic seq_quiet;
  assign seq_quiet = !redirect && !miss_stall;

  seq_incr_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    seq_quiet |=> (o_fetch_address == $past(o_fetch_address) + `PSCE_ADDR_ONE))
    else $error("fetch address did not increment");
  miss_defer_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (miss_stall && !redirect) |=> (o_fetch_stall && !o_instr_valid && $stable(o_fetch_address)) ##1 o_instr_valid)
    else $error("conflict miss not deferred one cycle");
  hit_nostall_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_pm_data_access && chit && !s_ff.stall) |=> (o_instr_valid && !o_fetch_stall))
    else $error("cache hit stalled");
  jump_nopush_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_branch && !i_is_call && !irq_any && !i_loop_start && !i_loop_end && !i_loop_pop && !s_ff.rsp_pv)
    |=> (s_ff.rsp == $past(s_ff.rsp)))
    else $error("jump changed return stack");
  ptr_late_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_ureg_wr && i_ureg_sel == `PSCE_R_RSTK_PTR && s_ff.rsp != `PSCE_PTR_OVF && !s_ff.rsp_pv
     && i_ureg_wdata[4:0] <= 5'(RSTK_DEPTH) && !i_branch && !i_return && !irq_any && !i_loop_start
     && !i_loop_end && !i_loop_pop) |=> (s_ff.rsp == $past(s_ff.rsp)) ##1 (s_ff.rsp == $past(i_ureg_wdata[4:0], 2)))
    else $error("stack pointer write latency wrong");
  mode_effect_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_ureg_wr && i_ureg_sel == `PSCE_R_SYS_BASE && !i_bitop_en && !i_sstk_pop)
    |=> (s_ff.sys[`PSCE_S_MODE_CONTROL_FIRST] == $past(i_ureg_wdata)) ##1 (s_ff.eff[`PSCE_S_MODE_CONTROL_FIRST] == $past(i_ureg_wdata, 2)))
    else $error("mode register latency wrong");
  never_true_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_cond_code == `PSCE_CC_ALWAYS) |=> (o_cond_true == !$past(i_cond_is_loop)))
    else $error("code 31 misread");
  bus_gate_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_cond_code == 5'h0E && s_ff.eff[`PSCE_S_MODE_CONTROL_FIRST][`PSCE_BM_EN0_BIT]) |=> !o_cond_true)
    else $error("bus owner condition not forced false");
  ro_ignore_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (i_ureg_wr && i_ureg_sel == `PSCE_R_EXEC && !miss_stall) |=> (s_ff.pc == $past(s_ff.da)))
    else $error("execute address written");
endmodule : psce_sequencer

// >>> sim/psce_pm_model.sv
// program memory model behind the sequencer's fetch port
// assumes a combinational answer at the current fetch address
`timescale 1ns/10ps
module psce_pm_model (
  input  wire logic [23:0] i_addr,
  output logic      [47:0] o_instr
);
  // ****************************************
  // instruction word derived from its address
  // ****************************************
  always_comb begin
    o_instr = {~i_addr, i_addr};
  end
endmodule : psce_pm_model

// >>> sim/tb.sv
// self-checking bench of the program sequencer
// assumes psce_pkg compiled first and the program memory model beside it
`timescale 1ns/10ps
module tb;
  import psce_pkg::*;
  logic        clk, resetn, data_acc, branch, is_call, ret, ureg_wr, bitop_en, cond_loop, owner;
  logic        valid, stall, cond_true, irq_take;
  logic        loop_start, loop_end, sstk_push, sstk_pop, exp_c;
  logic [23:0] fetch_addr, target, irq_vec, a;
  logic [47:0] pm_word, instr;
  logic [31:0] rdata, wdata, mask, irq_req, end_word, v, m1;
  logic [4:0]  sel, code;
  logic [8:0]  flags;
  logic [3:0]  pins;
  psce_bitop_t bitop;
  int          n_errors, checks_done, cycles;

  psce_pm_model pm (.i_addr(fetch_addr), .o_instr(pm_word));
  psce_sequencer dut (
    .i_clk(clk), .i_resetn(resetn), .i_pm_instr(pm_word), .i_pm_data_access(data_acc),
    .i_branch(branch), .i_is_call(is_call), .i_branch_target(target), .i_return(ret),
    .i_loop_start(loop_start), .i_loop_end_word(end_word), .i_loop_end(loop_end), .i_loop_pop(1'b0),
    .i_sstk_push(sstk_push), .i_sstk_pop(sstk_pop), .i_ureg_wr(ureg_wr), .i_ureg_sel(sel),
    .i_ureg_wdata(wdata), .i_bitop_en(bitop_en), .i_bitop(bitop), .i_bit_mask(mask),
    .i_cond_code(code), .i_cond_is_loop(cond_loop), .i_irq_req(irq_req),
    .i_alu_zero_flag(flags[0]), .i_alu_lt(flags[1]), .i_alu_le(flags[2]), .i_alu_carry_flag(flags[3]),
    .i_alu_overflow_flag(flags[4]), .i_mult_overflow_flag(flags[5]), .i_mult_negative_flag(flags[6]),
    .i_shift_overflow_flag(flags[7]), .i_shift_zero_flag(flags[8]), .i_gp_input_zero(pins[0]),
    .i_gp_input_one(pins[1]), .i_gp_input_two(pins[2]), .i_gp_input_three(pins[3]), .i_bus_owner(owner),
    .o_fetch_address(fetch_addr), .o_instr(instr), .o_instr_valid(valid), .o_fetch_stall(stall),
    .o_ureg_rdata(rdata), .o_cond_true(cond_true), .o_irq_take(irq_take), .o_irq_vector(irq_vec)
  );

  // ****************************************
  // clock, timeout, shared tasks
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_of_test

  task automatic check(input string what, input logic [47:0] exp, input logic [47:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick

  // write pulse, select left on the register for readback
  task automatic wr(input logic [4:0] s, input logic [31:0] d);
    sel = s;
    wdata = d;
    ureg_wr = 1'b1;
    tick(1);
    ureg_wr = 1'b0;
  endtask : wr

  task automatic jump(input logic call, input logic [23:0] t);
    target = t;
    is_call = call;
    branch = 1'b1;
    tick(1);
    branch = 1'b0;
  endtask : jump

  task automatic bop(input psce_bitop_t op, input logic [31:0] m);
    bitop = op;
    mask = m;
    bitop_en = 1'b1;
    tick(1);
    bitop_en = 1'b0;
  endtask : bop

  function automatic logic cond_exp(input logic [4:0] c, input logic lp, input logic [31:0] cnt,
                                    input logic tf, input logic bm);
    logic b;
    if (c == 5'h1F) return !lp;
    if (c == 5'h0F) return lp ? (cnt == 32'h0000_0001) : (cnt != 32'h0000_0001);
    if (c[3:0] <= 4'h8) b = flags[c[3:0]];
    else if (c[3:0] <= 4'hC) b = pins[c[3:0] - 4'h9];
    else if (c[3:0] == 4'hD) b = tf;
    else b = bm;
    return c[4] ? !b : b;
  endfunction : cond_exp

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {data_acc, branch, is_call, ret, ureg_wr, bitop_en, cond_loop, owner} = 8'h00;
    {target, wdata, mask, irq_req, sel, code, flags, pins} = '0;
    {loop_start, loop_end, sstk_push, sstk_pop} = 4'h0;
    bitop = PSCE_BIT_SET;
    resetn = 1'b0;
    void'($urandom(30));
    end_word = $urandom;
    tick(10);
    resetn = 1'b1;
    tick(3);
    for (int i = 0; i < 6; i++) begin
      a = fetch_addr;
      if (i % 2 == 1) wr(5'(i / 2), $urandom);
      else tick(1);
      check("fetch step", a + 24'h00_0001, fetch_addr);
    end
    tick(1);
    check("exec read", fetch_addr - 24'h00_0003, rdata);
    target = 24'($urandom);
    jump(1'b0, target);
    check("jump target", target, fetch_addr);
    sel = 5'h04;
    tick(3);
    check("ptr after jump", 48'h0, rdata);
    jump(1'b1, 24'($urandom));
    tick(3);
    check("ptr after call", 48'h1, rdata);
    ret = 1'b1;
    tick(1);
    ret = 1'b0;
    tick(3);
    check("ptr after return", 48'h0, rdata);
    a = 24'($urandom) & 24'h0F_FFFF;
    for (int k = 0; k < 2; k++) begin
      jump(1'b0, a);
      data_acc = 1'b1;
      tick(1);
      data_acc = 1'b0;
      check("conflict stall", 48'(k == 0), stall);
      if (k == 0) check("held fetch", a, fetch_addr);
      else check("cached word", {~a, a}, instr);
      tick(1);
      check("instr valid", 48'h1, valid);
      if (k == 0) check("filled word", {~a, a}, instr);
    end
    wr(5'h04, 32'h0000_0003);
    check("ptr old", 48'h0, rdata);
    tick(2);
    check("ptr new", 48'h3, rdata);
    v = $urandom;
    wr(5'h0C, v);
    check("nest ptr old", 48'h0, rdata);
    tick(2);
    check("nest ptr new", v, rdata);
    for (int r = 0; r < 6; r++) begin
      flags = 9'($urandom);
      pins = 4'($urandom);
      owner = (r > 1) ? 1'b1 : 1'($urandom);
      m1 = 32'(r % 4) << 17;
      v = 32'(r % 3);
      wr(5'h08, m1);
      tick(1);
      wr(5'h0D, 32'(r % 2) << 18);
      tick(1);
      wr(5'h06, v);
      tick(4);
      for (int c = 0; c < 64; c++) begin
        code = 5'(c % 32);
        cond_loop = (c >= 32);
        tick(1);
        exp_c = cond_exp(code, cond_loop, v, 1'(r % 2), owner & (m1[18:17] == 2'b00));
        check("cond code", 48'(exp_c), 48'(cond_true));
      end
    end
    v = $urandom;
    wr(5'h10, v);
    for (int i = 0; i < 3; i++) begin
      m1 = $urandom;
      bop(psce_bitop_t'(i), m1);
      v = (i == 0) ? (v | m1) : (i == 1) ? (v & ~m1) : (v ^ m1);
      tick(1);
      check("bit op", v, rdata);
    end
    bop(PSCE_BIT_TST, v & 32'($urandom));
    code = 5'h0D;
    tick(4);
    check("test flag set", 48'h1, cond_true);
    bop(PSCE_BIT_XOR, ~v);
    tick(4);
    check("xor flag clear", 48'h0, cond_true);
    for (int s = 6; s <= 16; s++) begin
      v = (s == 10) ? 32'h0000_0000 : $urandom;
      wr(5'(s), v);
      tick((s == 12) ? 2 : 1);
      check("reg readback", v, rdata);
    end
    wr(5'h11, $urandom);
    tick(1);
    check("unmapped read", 48'h0, rdata);
    // two-pass loop ending on an expired count
    wr(5'h07, 32'h0000_0002);
    end_word = {3'h0, 5'h0F, 24'($urandom)};
    a = fetch_addr - 24'h00_0001;
    sel = 5'h05;
    loop_start = 1'b1;
    tick(1);
    loop_start = 1'b0;
    tick(1);
    check("loop top word", end_word, rdata);
    for (int k = 0; k < 2; k++) begin
      loop_end = 1'b1;
      tick(1);
      loop_end = 1'b0;
      check("loop fetch", (k == 0) ? a : a + 24'h00_0001, fetch_addr);
    end
    wr(5'h05, $urandom);
    tick(1);
    check("loop stack empty", 48'h0, rdata);
    // status stack round trip
    m1 = $urandom;
    wr(5'h08, m1);
    sstk_push = 1'b1;
    tick(1);
    sstk_push = 1'b0;
    wr(5'h08, ~m1);
    sstk_pop = 1'b1;
    tick(1);
    sstk_pop = 1'b0;
    tick(1);
    check("status pop", m1, rdata);
    wr(5'h0B, 32'h0000_0008);
    tick(3);
    irq_req = 32'h0000_0008;
    tick(1);
    irq_req = 32'h0000_0000;
    for (int i = 0; i < 6 && irq_take !== 1'b1; i++) tick(1);
    check("irq taken", 48'h1, irq_take);
    check("irq vector", 48'h0C, irq_vec);
    end_of_test();
  end
endmodule : tb
